/* File: rtl/sep_pkg.sv */
// shared constants and types of the serial memory port
// assumes one system clock at CLK_HZ and a host-driven serial clock
package sep_pkg;

    // ********************************
    // instruction encodings
    // ********************************
    localparam logic [3:0] OPC_UPPER_ZERO = 4'h0;
    localparam int OPC_ADDR8_POS = 3;
    localparam logic [2:0] OPC_READ_LOW = 3'h3;
    localparam logic [2:0] OPC_WRITE_LOW = 3'h2;
    localparam logic [7:0] LATCH_DISABLE_OPCODE = 8'h04;
    localparam logic [7:0] LATCH_ENABLE_OPCODE = 8'h06;
    localparam logic [7:0] STATUS_READ_OPCODE = 8'h05;
    localparam logic [7:0] STATUS_WRITE_OPCODE = 8'h01;

    // ********************************
    // status byte layout, resets and protection bases
    // ********************************
    localparam int STAT_BUSY_POS = 0;
    localparam int STAT_LATCH_POS = 1;
    localparam int STAT_PROT_LOW_POS = 2;
    localparam int STAT_PROT_HIGH_POS = 3;
    localparam logic [1:0] PROT_RESET = 2'h0;
    localparam logic [8:0] QUARTER_BASE = 9'h180;
    localparam logic [8:0] HALF_BASE = 9'h100;

    // ********************************
    // array geometry and timing
    // ********************************
    localparam int MEM_BYTES = 512;
    localparam int PAGE_BYTES = 16;
    localparam int TWC_MS = 5;
    localparam int unsigned CLK_HZ = 25000000;
    localparam int unsigned TWC_CYCLES = TWC_MS * (CLK_HZ / 1000);

    // ********************************
    // types
    // ********************************
    typedef enum logic [2:0] {
        RES_NONE,
        RES_LATCH_SET,
        RES_LATCH_CLR,
        RES_STATUS_WR,
        RES_ARRAY_WR
    } sep_res_t;

    // array addresses hit by the protection field
    function automatic logic prot_hit(input logic [1:0] prot, input logic [8:0] addr);
        logic hit;
        hit = 1'b0;
        case (prot)
            2'h0: hit = 1'b0;
            2'h1: hit = (addr >= QUARTER_BASE);
            2'h2: hit = (addr >= HALF_BASE);
            default: hit = 1'b1;
        endcase
        return hit;
    endfunction

endpackage

/* File: rtl/sep_link_if.sv */
// signals between the serial front end and the nonvolatile core
// front fields are quasi-static once chip select has risen
`timescale 1ns/1ps
interface sep_link_if;
    logic [8:0] rd_addr;
    logic [7:0] rd_data;
    sep_pkg::sep_res_t res_kind;
    logic res_tag;
    logic [7:0] st_data;
    logic [4:0] pg_base;
    logic [7:0] pg_data [sep_pkg::PAGE_BYTES];
    logic [15:0] pg_mask;
    logic frame_end;
    logic wp_low;
    logic busy;
    logic latch;
    logic [1:0] prot;

    modport core (
        input rd_addr, res_kind, res_tag, st_data, pg_base, pg_data, pg_mask,
        input frame_end, wp_low,
        output rd_data, busy, latch, prot
    );
    modport front (
        output rd_addr, res_kind, res_tag, st_data, pg_base, pg_data, pg_mask,
        output frame_end, wp_low,
        input rd_data, busy, latch, prot
    );
endinterface

/* File: rtl/sep_nv_core.sv */
// nonvolatile core: array, latch, protection field, write cycle timer
// assumes front results are stable when frame_end pulses
`timescale 1ns/1ps
module sep_nv_core #(
    parameter int unsigned WRITE_CYCLES = sep_pkg::TWC_CYCLES
) (
    input wire logic clk_in,
    input wire logic rst_in,
    sep_link_if.core lnk
);
    typedef enum logic [1:0] {CS_IDLE, CS_PROG, CS_WAIT} sep_core_t;

    logic [7:0] mem_q [sep_pkg::MEM_BYTES];
    sep_core_t st_q, st_d;
    logic [3:0] idx_q, idx_d;
    logic [31:0] tmr_q, tmr_d;
    logic latch_q, latch_d;
    logic [1:0] prot_q, prot_d;
    logic seen_q, seen_d;
    logic we;
    logic [8:0] waddr;
    logic allow;

    assign lnk.rd_data = mem_q[lnk.rd_addr];
    assign lnk.busy = (st_q != CS_IDLE);
    assign lnk.latch = latch_q;
    assign lnk.prot = prot_q;

    // ********************************
    // next state
    // ********************************
    always_comb begin
        st_d = st_q;
        idx_d = idx_q;
        tmr_d = tmr_q;
        latch_d = latch_q;
        prot_d = prot_q;
        seen_d = seen_q;
        we = 1'b0;
        waddr = {lnk.pg_base, idx_q};
        allow = latch_q && !lnk.wp_low;
        case (st_q)
            CS_IDLE: begin
                if (lnk.frame_end) begin
                    seen_d = lnk.res_tag;
                    if (lnk.res_tag != seen_q) begin
                        case (lnk.res_kind)
                            sep_pkg::RES_LATCH_SET: latch_d = !lnk.wp_low;
                            sep_pkg::RES_LATCH_CLR: latch_d = 1'b0;
                            sep_pkg::RES_STATUS_WR: begin
                                if (allow) begin
                                    prot_d = {lnk.st_data[sep_pkg::STAT_PROT_HIGH_POS],
                                        lnk.st_data[sep_pkg::STAT_PROT_LOW_POS]};
                                    st_d = CS_WAIT;
                                    tmr_d = 32'h0;
                                end
                            end
                            sep_pkg::RES_ARRAY_WR: begin
                                if (allow && !sep_pkg::prot_hit(prot_q, {lnk.pg_base, 4'h0})) begin
                                    st_d = CS_PROG;
                                    idx_d = 4'h0;
                                    tmr_d = 32'h0;
                                end
                            end
                            default: ;
                        endcase
                    end
                end
            end
            CS_PROG: begin
                we = lnk.pg_mask[idx_q];
                idx_d = idx_q + 4'h1;
                tmr_d = tmr_q + 32'h1;
                if (idx_q == 4'hf) begin
                    st_d = CS_WAIT;
                end
            end
            CS_WAIT: begin
                tmr_d = tmr_q + 32'h1;
                if (tmr_q >= WRITE_CYCLES - 32'h1) begin
                    st_d = CS_IDLE;
                    latch_d = 1'b0;
                end
            end
            default: st_d = CS_IDLE;
        endcase
        if (lnk.frame_end && st_q != CS_IDLE) begin
            seen_d = lnk.res_tag;
        end
        if (lnk.wp_low) begin
            latch_d = 1'b0;
        end
    end

    // ********************************
    // registers
    // ********************************
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_q <= CS_IDLE;
            idx_q <= 4'h0;
            tmr_q <= 32'h0;
            latch_q <= 1'b0;
            prot_q <= sep_pkg::PROT_RESET;
            seen_q <= 1'b0;
        end else begin
            st_q <= st_d;
            idx_q <= idx_d;
            tmr_q <= tmr_d;
            latch_q <= latch_d;
            prot_q <= prot_d;
            seen_q <= seen_d;
        end
    end

    always_ff @(posedge clk_in) begin
        if (we) begin
            mem_q[waddr] <= lnk.pg_data[idx_q];
        end
    end
endmodule

/* File: rtl/sep_serial_port.sv */
// serial slave front end of a 512-byte nonvolatile memory
// assumes sck_in is the host clock, stopped outside frames;
// cs_n_in high resets the frame logic of the serial clock domain
`timescale 1ns/1ps

module sep_serial_port #(
    parameter int unsigned WRITE_CYCLES = sep_pkg::TWC_CYCLES
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic sck_in,
    input wire logic cs_n_in,
    input wire logic si_in,
    input wire logic hold_n_in,
    input wire logic wp_n_in,
    output logic so_out,
    output logic so_oe_out
);
    typedef enum logic [2:0] {
        PH_OPC,
        PH_ADDR,
        PH_RD,
        PH_WR,
        PH_STAT_RD,
        PH_STAT_WR,
        PH_IGN
    } sep_phase_t;

    sep_link_if lnk ();

    sep_nv_core #(
        .WRITE_CYCLES(WRITE_CYCLES)
    ) u_core (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .lnk(lnk.core)
    );

    // ********************************
    // system clock side of the pins
    // ********************************
    logic cs_meta_q, cs_meta_d, cs_sync_q, cs_sync_d, cs_prev_q, cs_prev_d;
    logic wp_meta_q, wp_meta_d, wp_sync_q, wp_sync_d;

    always_comb begin
        cs_meta_d = cs_n_in;
        cs_sync_d = cs_meta_q;
        cs_prev_d = cs_sync_q;
        wp_meta_d = wp_n_in;
        wp_sync_d = wp_meta_q;
    end

    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cs_meta_q <= 1'b1;
            cs_sync_q <= 1'b1;
            cs_prev_q <= 1'b1;
            wp_meta_q <= 1'b0;
            wp_sync_q <= 1'b0;
        end else begin
            cs_meta_q <= cs_meta_d;
            cs_sync_q <= cs_sync_d;
            cs_prev_q <= cs_prev_d;
            wp_meta_q <= wp_meta_d;
            wp_sync_q <= wp_sync_d;
        end
    end

    // commit needs a low-to-high select edge
    assign lnk.frame_end = cs_sync_q && !cs_prev_q;
    assign lnk.wp_low = !wp_sync_q;

    // ********************************
    // core state into the serial clock domain
    // ********************************
    logic bz_meta_q, bz_s_q, lt_meta_q, lt_s_q;
    logic [1:0] pr_meta_q, pr_s_q;
    logic [7:0] status_byte;

    always_ff @(posedge sck_in or posedge rst_in) begin
        if (rst_in) begin
            bz_meta_q <= 1'b0;
            bz_s_q <= 1'b0;
            lt_meta_q <= 1'b0;
            lt_s_q <= 1'b0;
            pr_meta_q <= sep_pkg::PROT_RESET;
            pr_s_q <= sep_pkg::PROT_RESET;
        end else begin
            bz_meta_q <= lnk.busy;
            bz_s_q <= bz_meta_q;
            lt_meta_q <= lnk.latch;
            lt_s_q <= lt_meta_q;
            pr_meta_q <= lnk.prot;
            pr_s_q <= pr_meta_q;
        end
    end

    always_comb begin
        status_byte = 8'h00;
        status_byte[sep_pkg::STAT_BUSY_POS] = bz_s_q;
        status_byte[sep_pkg::STAT_LATCH_POS] = lt_s_q;
        status_byte[sep_pkg::STAT_PROT_LOW_POS] = pr_s_q[0];
        status_byte[sep_pkg::STAT_PROT_HIGH_POS] = pr_s_q[1];
    end

    // ********************************
    // serial frame logic, rising edge
    // ********************************
    logic frame_rst;
    sep_phase_t phase_q, phase_d;
    logic [2:0] bit_q, bit_d;
    logic [7:0] sh_q, sh_d, op_q, op_d, tx_q, tx_d;
    logic [8:0] addr_q, addr_d;
    logic started_q, started_d;
    sep_pkg::sep_res_t res_q, res_d;
    logic tag_q, tag_d;
    logic [7:0] st_q, st_d;
    logic [4:0] base_q, base_d;
    logic [7:0] pg_q [sep_pkg::PAGE_BYTES];
    logic [7:0] pg_d [sep_pkg::PAGE_BYTES];
    logic [15:0] mask_q, mask_d;
    logic [7:0] in_byte;
    logic byte_done;
    logic is_read, is_write;

    assign frame_rst = rst_in || cs_n_in;

    always_comb begin
        phase_d = phase_q;
        bit_d = bit_q;
        sh_d = sh_q;
        op_d = op_q;
        tx_d = tx_q;
        addr_d = addr_q;
        started_d = started_q;
        res_d = res_q;
        tag_d = tag_q;
        st_d = st_q;
        base_d = base_q;
        pg_d = pg_q;
        mask_d = mask_q;
        in_byte = {sh_q[6:0], si_in};
        byte_done = (bit_q == 3'h7);
        // opcode decode with address bit eight
        is_read = (in_byte[7:4] == sep_pkg::OPC_UPPER_ZERO)
            && (in_byte[2:0] == sep_pkg::OPC_READ_LOW);
        is_write = (in_byte[7:4] == sep_pkg::OPC_UPPER_ZERO)
            && (in_byte[2:0] == sep_pkg::OPC_WRITE_LOW);
        if (hold_n_in) begin
            started_d = 1'b1;
            if (!started_q) begin
                tag_d = !tag_q;
            end
            // any extra bit cancels a pending write
            res_d = sep_pkg::RES_NONE;
            sh_d = in_byte;
            bit_d = bit_q + 3'h1;
            case (phase_q)
                PH_OPC: begin
                    if (byte_done) begin
                        op_d = in_byte;
                        phase_d = PH_IGN;
                        if (in_byte == sep_pkg::STATUS_READ_OPCODE) begin
                            tx_d = status_byte;
                            phase_d = PH_STAT_RD;
                        end else if (bz_s_q) begin
                            phase_d = PH_IGN;
                        end else if (is_read || is_write) begin
                            phase_d = PH_ADDR;
                            mask_d = 16'h0000;
                        end else if (in_byte == sep_pkg::LATCH_ENABLE_OPCODE) begin
                            res_d = sep_pkg::RES_LATCH_SET;
                        end else if (in_byte == sep_pkg::LATCH_DISABLE_OPCODE) begin
                            res_d = sep_pkg::RES_LATCH_CLR;
                        end else if (in_byte == sep_pkg::STATUS_WRITE_OPCODE) begin
                            phase_d = PH_STAT_WR;
                        end
                    end
                end
                PH_ADDR: begin
                    if (byte_done) begin
                        addr_d = {op_q[sep_pkg::OPC_ADDR8_POS], in_byte};
                        if (op_q[2:0] == sep_pkg::OPC_READ_LOW) begin
                            tx_d = lnk.rd_data;
                            phase_d = PH_RD;
                        end else begin
                            base_d = {op_q[sep_pkg::OPC_ADDR8_POS], in_byte[7:4]};
                            phase_d = PH_WR;
                        end
                    end
                end
                PH_RD: begin
                    if (byte_done) begin
                        addr_d = addr_q + 9'h001;
                        tx_d = lnk.rd_data;
                    end
                end
                PH_WR: begin
                    if (byte_done) begin
                        pg_d[addr_q[3:0]] = in_byte;
                        mask_d[addr_q[3:0]] = 1'b1;
                        addr_d = {addr_q[8:4], addr_q[3:0] + 4'h1};
                        res_d = sep_pkg::RES_ARRAY_WR;
                    end
                end
                PH_STAT_RD: begin
                    if (byte_done) begin
                        tx_d = status_byte;
                    end
                end
                PH_STAT_WR: begin
                    if (byte_done) begin
                        st_d = in_byte;
                        res_d = sep_pkg::RES_STATUS_WR;
                        phase_d = PH_IGN;
                    end
                end
                PH_IGN: ;
                default: phase_d = PH_IGN;
            endcase
        end
    end

    assign lnk.rd_addr = addr_d;

    always_ff @(posedge sck_in or posedge frame_rst) begin
        if (frame_rst) begin
            phase_q <= PH_OPC;
            bit_q <= 3'h0;
            sh_q <= 8'h00;
            op_q <= 8'h00;
            tx_q <= 8'h00;
            addr_q <= 9'h000;
            started_q <= 1'b0;
        end else begin
            phase_q <= phase_d;
            bit_q <= bit_d;
            sh_q <= sh_d;
            op_q <= op_d;
            tx_q <= tx_d;
            addr_q <= addr_d;
            started_q <= started_d;
        end
    end

    // results outlive the frame for the core to read
    always_ff @(posedge sck_in or posedge rst_in) begin
        if (rst_in) begin
            res_q <= sep_pkg::RES_NONE;
            tag_q <= 1'b0;
            st_q <= 8'h00;
            base_q <= 5'h00;
            pg_q <= '{default: 8'h00};
            mask_q <= 16'h0000;
        end else begin
            res_q <= res_d;
            tag_q <= tag_d;
            st_q <= st_d;
            base_q <= base_d;
            pg_q <= pg_d;
            mask_q <= mask_d;
        end
    end

    assign lnk.res_kind = res_q;
    assign lnk.res_tag = tag_q;
    assign lnk.st_data = st_q;
    assign lnk.pg_base = base_q;
    assign lnk.pg_data = pg_q;
    assign lnk.pg_mask = mask_q;

    // ********************************
    // serial output, falling edge
    // ********************************
    logic so_q, so_d, drive_q, drive_d;

    always_comb begin
        so_d = so_q;
        drive_d = drive_q;
        // pause freezes output at falling edge
        if (hold_n_in) begin
            so_d = tx_q[3'h7 - bit_q];
            drive_d = (phase_q == PH_RD) || (phase_q == PH_STAT_RD);
        end
    end

    always_ff @(negedge sck_in or posedge frame_rst) begin
        if (frame_rst) begin
            so_q <= 1'b0;
            drive_q <= 1'b0;
        end else begin
            so_q <= so_d;
            drive_q <= drive_d;
        end
    end

    assign so_out = so_q;
    assign so_oe_out = !cs_n_in && hold_n_in && drive_q;
endmodule

/* File: sim/sep_serial_port_monitor.sv */
// checker of the serial memory port pins
// assumes cs_n_in is high while rst_in is high
`timescale 1ns/1ps
module sep_serial_port_monitor #(
    parameter int unsigned WRITE_CYCLES = sep_pkg::TWC_CYCLES
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic sck_in,
    input wire logic cs_n_in,
    input wire logic si_in,
    input wire logic hold_n_in,
    input wire logic wp_n_in,
    input wire logic so_out,
    input wire logic so_oe_out
);
    // ********************************
    // frame bit counter and opcode
    // ********************************
    logic [7:0] cnt_q;
    logic [7:0] opc_q;
    logic is_rd;
    logic is_st;
    always_ff @(posedge sck_in or posedge cs_n_in) begin
        if (cs_n_in) begin
            cnt_q <= 8'h00;
            opc_q <= 8'hff;
        end else if (hold_n_in) begin
            if (cnt_q != 8'hff) cnt_q <= cnt_q + 8'h01;
            if (cnt_q < 8'h08) opc_q <= {opc_q[6:0], si_in};
        end
    end
    assign is_rd = opc_q[7:4] == 4'h0 && opc_q[2:0] == sep_pkg::OPC_READ_LOW;
    assign is_st = opc_q == sep_pkg::STATUS_READ_OPCODE;

    // ********************************
    // assertions
    // ********************************
    chk_deselect_idle:
        assert property (@(posedge clk_in) disable iff (rst_in) cs_n_in |-> !so_oe_out)
            else $error("output on while deselected");
    chk_reset_quiet:
        assert property (@(posedge clk_in) rst_in |-> !so_oe_out && !so_out)
            else $error("output on in reset");
    chk_pause_idle:
        assert property (@(posedge clk_in) disable iff (rst_in) !hold_n_in |-> !so_oe_out)
            else $error("output on while paused");
    chk_output_late:
        assert property (@(negedge sck_in) disable iff (rst_in || cs_n_in)
            so_oe_out |-> cnt_q >= 8'h09) else $error("output before opcode done");
    chk_read_wait:
        assert property (@(negedge sck_in) disable iff (rst_in || cs_n_in)
            is_rd && cnt_q < 8'h11 |-> !so_oe_out) else $error("read data too early");
    chk_other_quiet:
        assert property (@(negedge sck_in) disable iff (rst_in || cs_n_in)
            cnt_q >= 8'h09 && !is_rd && !is_st |-> !so_oe_out) else $error("output on no read");
    chk_status_drive:
        assert property (@(negedge sck_in) disable iff (rst_in || cs_n_in)
            is_st && cnt_q >= 8'h09 && hold_n_in |-> so_oe_out) else $error("status not sent");
    chk_status_upper:
        assert property (@(negedge sck_in) disable iff (rst_in || cs_n_in)
            is_st && cnt_q >= 8'h09 && cnt_q <= 8'h0c |-> !so_out) else $error("status top set");
endmodule

bind sep_serial_port sep_serial_port_monitor #(.WRITE_CYCLES(WRITE_CYCLES)) u_mon (
    .clk_in(clk_in), .rst_in(rst_in), .sck_in(sck_in), .cs_n_in(cs_n_in), .si_in(si_in),
    .hold_n_in(hold_n_in), .wp_n_in(wp_n_in), .so_out(so_out), .so_oe_out(so_oe_out));

/* File: sim/sep_host_model.sv */
// host side of the serial link, clocking only inside frames
// assumes the device drives so_in while so_oe_in is high
`timescale 1ns/1ps
module sep_host_model (
    input wire logic clk_in,
    input wire logic so_in,
    input wire logic so_oe_in,
    output logic sck_out = 1'b0,
    output logic cs_n_out,
    output logic si_out = 1'b0,
    output logic hold_n_out = 1'b1
);
    logic [7:0] rx_byte = 8'h00;
    logic last = 1'b0;
    event got;
    // deselect edge after time zero so every async reset sees it
    initial #1 cs_n_out = 1'b1;
    wire so_line = so_oe_in ? so_in : !last;
    task automatic start();
        @(negedge clk_in);
        cs_n_out = 1'b0;
        #7;
    endtask
    task automatic stop();
        @(negedge clk_in);
        cs_n_out = 1'b1;
        repeat (5) @(negedge clk_in);
    endtask
    // msb first, sampled on rising edge
    task automatic xbits(input logic [7:0] tx, input int n, input bit chk, input bit pz);
        for (int i = 0; i < n; i++) begin
            si_out = tx[7 - i];
            // pause with sck low, stray edges meanwhile
            if (pz && i == 3) begin
                #1 hold_n_out = 1'b0;
                repeat (3) begin
                    si_out = !si_out;
                    #3 sck_out = 1'b1;
                    #3 sck_out = 1'b0;
                end
                #1 hold_n_out = 1'b1;
                si_out = tx[7 - i];
                #3;
            end
            #3 sck_out = 1'b1;
            rx_byte = {rx_byte[6:0], so_line};
            last = so_line;
            #3 sck_out = 1'b0;
        end
        if (chk) -> got;
    endtask
endmodule

/* File: sim/tb.sv */
// self-checking bench of the serial memory port
// assumes the host model and the bound checker
`timescale 1ns/1ps
module tb;
    logic clk_in = 1'b0;
    logic rst_in = 1'b0;
    logic wp_n_in = 1'b1;
    logic sck, cs_n, si, hold_n, so, so_oe;
    logic [7:0] mem [512];
    logic [7:0] exp_q [$];
    logic [1:0] prot = 2'h0;
    int error_cnt = 0;
    int num_checks = 0;
    int cyc = 0;
    integer seed = 32'ha3889ffa;

    sep_serial_port #(.WRITE_CYCLES(40)) DUT (.clk_in(clk_in), .rst_in(rst_in),
        .sck_in(sck), .cs_n_in(cs_n), .si_in(si), .hold_n_in(hold_n), .wp_n_in(wp_n_in),
        .so_out(so), .so_oe_out(so_oe));
    sep_host_model host (.clk_in(clk_in), .so_in(so), .so_oe_in(so_oe), .sck_out(sck),
        .cs_n_out(cs_n), .si_out(si), .hold_n_out(hold_n));

    initial forever #20 clk_in = ~clk_in;

    // ********************************
    // tasks
    // ********************************
    task automatic conclude();
        if (error_cnt == 0 && num_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic op(input logic [7:0] b, input int extra);
        host.start();
        host.xbits(b, 8, 1'b0, 1'b0);
        host.xbits(8'h00, extra, 1'b0, 1'b0);
        host.stop();
    endtask
    task automatic st(input logic [7:0] e);
        host.start();
        host.xbits(sep_pkg::STATUS_READ_OPCODE, 8, 1'b0, 1'b0);
        exp_q.push_back(e);
        host.xbits(8'h00, 8, 1'b1, 1'b0);
        host.stop();
    endtask
    task automatic wr(input logic [8:0] a, input int n, input int tail, input bit poll);
        logic [7:0] d;
        logic ok;
        ok = wp_n_in && tail == 0 && !(prot == 2'h3 || (prot == 2'h2 && a >= 9'h100)
            || (prot == 2'h1 && a >= 9'h180));
        op(sep_pkg::LATCH_ENABLE_OPCODE, 0);
        host.start();
        host.xbits({4'h0, a[8], 3'h2}, 8, 1'b0, 1'b0);
        host.xbits(a[7:0], 8, 1'b0, 1'b0);
        for (int i = 0; i < n; i++) begin
            d = 8'($random(seed));
            host.xbits(d, 8, 1'b0, 1'b0);
            if (ok) mem[{a[8:4], 4'(a[3:0] + i)}] = d;
        end
        host.xbits(8'h00, tail, 1'b0, 1'b0);
        host.stop();
        if (poll) st(8'h03);
        repeat (50) @(negedge clk_in);
    endtask
    task automatic rd(input logic [8:0] a, input int n);
        host.start();
        host.xbits({4'h0, a[8], 3'h3}, 8, 1'b0, 1'b0);
        host.xbits(a[7:0], 8, 1'b0, 1'b0);
        for (int i = 0; i < n; i++) begin
            exp_q.push_back(mem[9'(a + i)]);
            host.xbits(8'($random(seed)), 8, 1'b1, i == 1);
        end
        host.stop();
    endtask

    // ********************************
    // result checker and timeout
    // ********************************
    always @(host.got) begin
        num_checks++;
        if (exp_q.size() == 0 || host.rx_byte !== exp_q[0]) begin
            error_cnt++;
            $display("unexpected at %0t: got %h want %h", $time, host.rx_byte,
                exp_q.size() != 0 ? exp_q[0] : 8'hxx);
        end
        if (exp_q.size() != 0) void'(exp_q.pop_front());
    end
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            error_cnt++;
            conclude();
        end
    end

    // ********************************
    // main sequence
    // ********************************
    initial begin
        #1 rst_in = 1'b1;
        repeat (8) @(negedge clk_in);
        rst_in = 1'b0;
        repeat (3) @(negedge clk_in);
        st(8'h00);
        op(sep_pkg::LATCH_ENABLE_OPCODE, 0);
        st(8'h02);
        op(sep_pkg::LATCH_DISABLE_OPCODE, 0);
        st(8'h00);
        op(sep_pkg::LATCH_ENABLE_OPCODE, 3);
        st(8'h00);
        op(8'hf0, 8);
        st(8'h00);
        wr(9'h000, 2, 0, 1'b0);
        wr(9'h1f8, 18, 0, 1'b1);
        st(8'h00);
        rd(9'h1f8, 10);
        wr(9'h001, 1, 3, 1'b0);
        rd(9'h000, 2);
        op(sep_pkg::LATCH_ENABLE_OPCODE, 0);
        wp_n_in = 1'b0;
        repeat (4) @(negedge clk_in);
        st(8'h00);
        wr(9'h000, 1, 0, 1'b0);
        wp_n_in = 1'b1;
        repeat (4) @(negedge clk_in);
        rd(9'h000, 1);
        for (int p = 0; p < 4; p++) begin
            op(sep_pkg::LATCH_ENABLE_OPCODE, 0);
            host.start();
            host.xbits(sep_pkg::STATUS_WRITE_OPCODE, 8, 1'b0, 1'b0);
            host.xbits({4'h0, 2'(p), 2'h0}, 8, 1'b0, 1'b0);
            host.stop();
            prot = 2'(p);
            repeat (50) @(negedge clk_in);
            st({4'h0, 2'(p), 2'h0});
            wr(9'h100, 1, 0, 1'b0);
            wr(9'h180, 1, 0, 1'b0);
            rd(9'h100, 1);
            rd(9'h180, 1);
        end
        if (exp_q.size() != 0) error_cnt++;
        conclude();
    end
endmodule
